// file: logic/bmf_defs.vh
// Constants for the bus-matching first-in-first-out buffer
`ifndef BMF_DEFS_VH
`define BMF_DEFS_VH

`define BMF_DATA_W      72
`define BMF_DEPTH       64
`define BMF_ADDR_W      6
`define BMF_PTR_W       7
`define BMF_DEPTH_CNT   7'h40
`define BMF_HALF_CNT    7'h20
`define BMF_OFS_W       6
`define BMF_NARROW36    36
`define BMF_NARROW18    18
`define BMF_SHIFT72     2'h0
`define BMF_SHIFT36     2'h1
`define BMF_SHIFT18     2'h2
`define BMF_FT_LAST     2'h2

// Preset offsets, index is {load select, sel1, sel0}
`define BMF_OFS_PRE0    6'h07
`define BMF_OFS_PRE1    6'h0f
`define BMF_OFS_PRE2    6'h01
`define BMF_OFS_PRE3    6'h03
`define BMF_OFS_PRE4    6'h1f
`define BMF_OFS_PRE5    6'h02
`define BMF_OFS_PRE6    6'h04
`define BMF_OFS_PRE7    6'h08

`endif

// file: logic/bmf_edge.v
// Rising and falling edge finder for a sampled port signal
`timescale 1ns/1ps
`default_nettype none
module bmf_edge (
   input  wire clock,
   input  wire rst,
   input  wire sig,
   output wire rise,
   output wire fall
);
   reg last_r;   // Level seen on the previous clock

   // Remember last level
   always @(posedge clock) begin
      if (rst) begin
         last_r <= 1'b0;
      end else begin
         last_r <= sig;
      end
   end

   assign rise = sig & ~last_r;
   assign fall = ~sig & last_r;
endmodule
`default_nettype wire

// file: logic/bmf_mem.v
// Word storage array for the buffer
`timescale 1ns/1ps
`default_nettype none
`include "bmf_defs.vh"
module bmf_mem (
   input  wire                      clock,
   input  wire                      we,
   input  wire [`BMF_ADDR_W-1:0]    wAddr,
   input  wire [`BMF_DATA_W-1:0]    wData,
   input  wire [`BMF_ADDR_W-1:0]    rAddr,
   output wire [`BMF_DATA_W-1:0]    rData
);
   reg [`BMF_DATA_W-1:0] store [0:`BMF_DEPTH-1];   // Full-width words

   // Write port, no reset: contents are meaningless until written
   always @(posedge clock) begin
      if (we) begin
         store[wAddr] <= wData;
      end
   end

   // Read is combinational so a fetch lands in one cycle
   assign rData = store[rAddr];
endmodule
`default_nettype wire

// file: logic/bmf_fifo_top.v
// Bus-matching buffer: write and read ports, offsets, flags, replay
`timescale 1ns/1ps
`default_nettype none
`include "bmf_defs.vh"
module bmf_fifo_top (
   input  wire                   clock,
   input  wire                   rst,
   input  wire                   masterResetN,
   input  wire                   partialResetN,
   input  wire                   inClock,
   input  wire                   inEnableN,
   input  wire                   inStrobe,
   input  wire                   inTimingStyleSel,
   input  wire                   inPortWidthSel,
   input  wire                   outPortWidthSel,
   input  wire                   busSizeMatchSel,
   input  wire [`BMF_DATA_W-1:0] inDataBus,
   input  wire                   outClock,
   input  wire                   outEnableN,
   input  wire                   outStrobe,
   input  wire                   outTimingStyleSel,
   input  wire                   outChipSelectN,
   input  wire                   outDriveEnableN,
   output reg  [`BMF_DATA_W-1:0] outDataBus,
   output wire                   outDataOe,
   output reg                    echoOutClock,
   output reg                    echoOutEnableN,
   input  wire                   fallthroughSelSerialInput,
   input  wire                   serialClock,
   input  wire                   serialLoadEnableN,
   input  wire                   offsetLoadSelN,
   input  wire                   defaultOffsetSel0,
   input  wire                   defaultOffsetSel1,
   input  wire                   flagTimingSel,
   input  wire                   markIn,
   input  wire                   replayRequestN,
   output wire                   emptyFlagN,
   output wire                   fullFlagN,
   output wire                   halfLevelFlagN,
   output reg                    almostEmptyFlagN,
   output reg                    almostFullFlagN
);
   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on the sampled port pins
   ////////////////////////////////////////////////////////////////////////////
   wire inRise;      // Write clock rose
   wire outRise;     // Read clock rose
   wire outFall;     // Read clock fell
   wire serRise;     // Serial clock rose
   wire inStbRise;   // Write strobe rose
   wire outStbRise;  // Read strobe rose

   // Each port is watched separately, so no rate relation is assumed
   bmf_edge uInClk  (.clock(clock), .rst(rst), .sig(inClock),
                     .rise(inRise), .fall());
   bmf_edge uOutClk (.clock(clock), .rst(rst), .sig(outClock),
                     .rise(outRise), .fall(outFall));
   bmf_edge uSerClk (.clock(clock), .rst(rst), .sig(serialClock),
                     .rise(serRise), .fall());
   bmf_edge uInStb  (.clock(clock), .rst(rst), .sig(inStrobe),
                     .rise(inStbRise), .fall());
   bmf_edge uOutStb (.clock(clock), .rst(rst), .sig(outStrobe),
                     .rise(outStbRise), .fall());

   ////////////////////////////////////////////////////////////////////////////
   // Mode latches and offsets
   ////////////////////////////////////////////////////////////////////////////
   reg                  syncWr_r;     // Write port clocked
   reg                  syncRd_r;     // Read port clocked
   reg                  fwft_r;       // Fall-through timing
   reg                  syncFlags_r;  // Threshold flags synchronous
   reg [1:0]            inShift_r;    // Write width code
   reg [1:0]            outShift_r;   // Read width code
   reg [`BMF_OFS_W-1:0] aeOfs_r;      // Almost-empty offset
   reg [`BMF_OFS_W-1:0] afOfs_r;      // Almost-full offset
   reg                  ofsWrSel_r;   // Next parallel load targets full
   reg                  ofsRdSel_r;   // Next offset read returns full
   reg [`BMF_OFS_W-1:0] presetOfs;    // Preset chosen by the pins

   // Preset table lookup
   always @* begin
      case ({offsetLoadSelN, defaultOffsetSel1, defaultOffsetSel0})
         3'h0:    presetOfs = `BMF_OFS_PRE0;
         3'h1:    presetOfs = `BMF_OFS_PRE1;
         3'h2:    presetOfs = `BMF_OFS_PRE2;
         3'h3:    presetOfs = `BMF_OFS_PRE3;
         3'h4:    presetOfs = `BMF_OFS_PRE4;
         3'h5:    presetOfs = `BMF_OFS_PRE5;
         3'h6:    presetOfs = `BMF_OFS_PRE6;
         default: presetOfs = `BMF_OFS_PRE7;
      endcase
   end

   // Port events; offset traffic is steered away from data
   wire wrEvt   = syncWr_r ? (inRise & ~inEnableN) : inStbRise;
   wire rdEvt   = syncRd_r ? (outRise & ~outEnableN) : outStbRise;
   wire dataWr  = wrEvt & offsetLoadSelN;
   wire dataRd  = rdEvt & offsetLoadSelN;
   wire ofsWr   = syncWr_r & wrEvt & ~offsetLoadSelN;
   wire ofsRd   = syncRd_r & rdEvt & ~offsetLoadSelN;
   wire serLoad = serRise & ~serialLoadEnableN & ~offsetLoadSelN;
   wire ptrClr  = ~masterResetN | ~partialResetN;

   // Modes and offsets; partial reset leaves all of these alone
   always @(posedge clock) begin
      if (rst) begin
         syncWr_r    <= 1'b1;
         syncRd_r    <= 1'b1;
         fwft_r      <= 1'b0;
         syncFlags_r <= 1'b0;
         inShift_r   <= `BMF_SHIFT72;
         outShift_r  <= `BMF_SHIFT72;
         aeOfs_r     <= `BMF_OFS_PRE0;
         afOfs_r     <= `BMF_OFS_PRE0;
         ofsWrSel_r  <= 1'b0;
         ofsRdSel_r  <= 1'b0;
      end else if (~masterResetN) begin
         // Pins are caught every cycle while master reset is held
         syncWr_r    <= inTimingStyleSel;
         syncRd_r    <= outTimingStyleSel;
         fwft_r      <= fallthroughSelSerialInput;
         syncFlags_r <= flagTimingSel;
         aeOfs_r     <= presetOfs;
         afOfs_r     <= presetOfs;
         ofsWrSel_r  <= 1'b0;
         ofsRdSel_r  <= 1'b0;
         // Width decode
         if (~busSizeMatchSel) begin
            inShift_r  <= `BMF_SHIFT72;
            outShift_r <= `BMF_SHIFT72;
         end else if (~inPortWidthSel) begin
            inShift_r  <= `BMF_SHIFT72;
            outShift_r <= outPortWidthSel ? `BMF_SHIFT18 : `BMF_SHIFT36;
         end else begin
            inShift_r  <= outPortWidthSel ? `BMF_SHIFT18 : `BMF_SHIFT36;
            outShift_r <= `BMF_SHIFT72;
         end
      end else begin
         // Serial chain: almost-empty bits first, low bit first
         if (serLoad) begin
            {afOfs_r, aeOfs_r} <= {fallthroughSelSerialInput,
                                   afOfs_r, aeOfs_r[`BMF_OFS_W-1:1]};
         end else if (ofsWr) begin
            if (ofsWrSel_r) begin
               afOfs_r <= inDataBus[`BMF_OFS_W-1:0];
            end else begin
               aeOfs_r <= inDataBus[`BMF_OFS_W-1:0];
            end
            ofsWrSel_r <= ~ofsWrSel_r;
         end
         if (ofsRd) begin
            ofsRdSel_r <= ~ofsRdSel_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write side: assemble narrow words into full words
   ////////////////////////////////////////////////////////////////////////////
   reg  [`BMF_PTR_W-1:0] wrPtr_r;   // Write pointer with wrap bit
   reg  [`BMF_PTR_W-1:0] rdPtr_r;   // Read pointer with wrap bit
   reg  [1:0]            wrPart_r;  // Narrow part being collected
   reg  [`BMF_DATA_W-1:0] asm_r;    // Partly built word
   reg  [`BMF_DATA_W-1:0] merged;   // Word with current part merged
   wire [`BMF_PTR_W-1:0] count = wrPtr_r - rdPtr_r;
   wire memEmpty = (count == {`BMF_PTR_W{1'b0}});
   wire memFull  = (count == `BMF_DEPTH_CNT);
   wire [1:0] lastIn  = (inShift_r == `BMF_SHIFT18) ? 2'h3 :
                        (inShift_r == `BMF_SHIFT36) ? 2'h1 : 2'h0;
   wire [1:0] lastOut = (outShift_r == `BMF_SHIFT18) ? 2'h3 :
                        (outShift_r == `BMF_SHIFT36) ? 2'h1 : 2'h0;
   wire wrLast = (wrPart_r == lastIn);
   wire doWrite = dataWr & ~memFull;   // Writes into a full buffer are dropped

   // Merge the incoming part into its lane, low part first
   always @* begin
      merged = asm_r;
      if (inShift_r == `BMF_SHIFT72) begin
         merged = inDataBus;
      end else if (inShift_r == `BMF_SHIFT36) begin
         if (wrPart_r[0]) begin
            merged[71:36] = inDataBus[35:0];
         end else begin
            merged[35:0] = inDataBus[35:0];
         end
      end else begin
         case (wrPart_r)
            2'h0:    merged[17:0]  = inDataBus[17:0];
            2'h1:    merged[35:18] = inDataBus[17:0];
            2'h2:    merged[53:36] = inDataBus[17:0];
            default: merged[71:54] = inDataBus[17:0];
         endcase
      end
   end

   // Write pointer and assembly
   always @(posedge clock) begin
      if (rst | ptrClr) begin
         wrPtr_r  <= {`BMF_PTR_W{1'b0}};
         wrPart_r <= 2'h0;
         asm_r    <= {`BMF_DATA_W{1'b0}};
      end else if (doWrite) begin
         if (wrLast) begin
            wrPtr_r  <= wrPtr_r + 7'h01;
            wrPart_r <= 2'h0;
            asm_r    <= {`BMF_DATA_W{1'b0}};
         end else begin
            wrPart_r <= wrPart_r + 2'h1;
            asm_r    <= merged;
         end
      end
   end

   wire [`BMF_DATA_W-1:0] memRd;   // Word at read pointer
   bmf_mem uMem (
      .clock (clock),
      .we    (doWrite & wrLast & ~rst & ~ptrClr),
      .wAddr (wrPtr_r[`BMF_ADDR_W-1:0]),
      .wData (merged),
      .rAddr (rdPtr_r[`BMF_ADDR_W-1:0]),
      .rData (memRd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read side: split full words, standard or fall-through timing
   ////////////////////////////////////////////////////////////////////////////
   reg  [`BMF_DATA_W-1:0] held_r;     // Word being handed out in parts
   reg                    holdValid_r; // Held word came from memory
   reg  [1:0]             rdPart_r;   // Part now on the output bus
   reg                    outValid_r; // Fall-through: bus holds unread data
   reg  [1:0]             ftCnt_r;    // Read clock transitions seen
   reg  [`BMF_PTR_W-1:0]  markPtr_r;  // Recorded replay location
   wire moreParts = holdValid_r & (rdPart_r != lastOut);
   wire avail     = moreParts | ~memEmpty;
   wire ftTick    = outRise | outFall;
   reg  adv;                           // Move next part to the bus
   reg  fromMem;                       // That part starts a new word
   reg  [1:0] nextPart;                // Part number put on the bus
   reg  [`BMF_DATA_W-1:0] src;         // Word the part comes from
   reg  [`BMF_DATA_W-1:0] sliceOut;    // Part placed in low bits

   // Decide whether to advance and which part goes out
   always @* begin
      adv = 1'b0;
      if (~fwft_r) begin
         adv = dataRd & avail;
      end else if (outValid_r) begin
         adv = dataRd & avail;
      end else begin
         adv = avail & ftTick & (ftCnt_r == `BMF_FT_LAST);
      end
      fromMem  = ~moreParts;
      nextPart = fromMem ? 2'h0 : rdPart_r + 2'h1;
      src      = fromMem ? memRd : held_r;
      sliceOut = {`BMF_DATA_W{1'b0}};
      if (outShift_r == `BMF_SHIFT72) begin
         sliceOut = src;
      end else if (outShift_r == `BMF_SHIFT36) begin
         sliceOut[35:0] = nextPart[0] ? src[71:36] : src[35:0];
      end else begin
         case (nextPart)
            2'h0:    sliceOut[17:0] = src[17:0];
            2'h1:    sliceOut[17:0] = src[35:18];
            2'h2:    sliceOut[17:0] = src[53:36];
            default: sliceOut[17:0] = src[71:54];
         endcase
      end
   end

   // Read pointer, held word, output bus, replay
   always @(posedge clock) begin
      if (rst | ptrClr) begin
         rdPtr_r     <= {`BMF_PTR_W{1'b0}};
         held_r      <= {`BMF_DATA_W{1'b0}};
         holdValid_r <= 1'b0;
         rdPart_r    <= 2'h0;
         outValid_r  <= 1'b0;
         ftCnt_r     <= 2'h0;
         markPtr_r   <= {`BMF_PTR_W{1'b0}};
         outDataBus  <= {`BMF_DATA_W{1'b0}};
      end else if (~replayRequestN) begin
         // Replay drops the word on the bus and restarts from the mark
         rdPtr_r     <= markPtr_r;
         holdValid_r <= 1'b0;
         rdPart_r    <= 2'h0;
         outValid_r  <= 1'b0;
         ftCnt_r     <= 2'h0;
      end else begin
         if (markIn & outRise & syncRd_r) begin
            markPtr_r <= holdValid_r ? rdPtr_r - 7'h01 : rdPtr_r;
         end
         if (ofsRd) begin
            outDataBus <= {{(`BMF_DATA_W-`BMF_OFS_W){1'b0}},
                           ofsRdSel_r ? afOfs_r : aeOfs_r};
         end else if (adv) begin
            outDataBus <= sliceOut;
            rdPart_r   <= nextPart;
            if (fromMem) begin
               held_r      <= memRd;
               holdValid_r <= 1'b1;
               rdPtr_r     <= rdPtr_r + 7'h01;
            end
         end
         // Fall-through bookkeeping
         if (fwft_r) begin
            if (adv) begin
               outValid_r <= 1'b1;
               ftCnt_r    <= 2'h0;
            end else if (outValid_r & dataRd) begin
               outValid_r <= 1'b0;   // Last word taken, bus now stale
            end else if (~outValid_r & avail & ftTick) begin
               ftCnt_r <= ftCnt_r + 2'h1;
            end else if (~avail) begin
               ftCnt_r <= 2'h0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output enables and echo signals
   ////////////////////////////////////////////////////////////////////////////
   reg csN_r;   // Chip select as sampled on the read clock

   // Select only acts at read clock edges; the drive enable acts at once
   always @(posedge clock) begin
      if (rst) begin
         csN_r <= 1'b0;
      end else if (outRise) begin
         csN_r <= outChipSelectN;
      end
   end

   assign outDataOe = ~csN_r & ~outDriveEnableN;

   // Echo lines only carry meaning with a clocked read port
   always @(posedge clock) begin
      if (rst) begin
         echoOutClock   <= 1'b0;
         echoOutEnableN <= 1'b1;
      end else begin
         echoOutClock   <= syncRd_r & outClock;
         echoOutEnableN <= syncRd_r ? outEnableN : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags, all active low
   ////////////////////////////////////////////////////////////////////////////
   // Standard: empty/full; fall-through: output-ready/input-ready
   assign emptyFlagN = fwft_r ? ~outValid_r : avail;
   assign fullFlagN  = fwft_r ? memFull : ~memFull;
   assign halfLevelFlagN = ~(count > `BMF_HALF_CNT);

   // Threshold compares on the settled count
   wire aeNow = (count <= {1'b0, aeOfs_r});
   wire afNow = (count >= (`BMF_DEPTH_CNT - {1'b0, afOfs_r}));
   reg  wrSeen_r;   // Write-side edge, one cycle late
   reg  rdSeen_r;   // Read-side edge, one cycle late

   // Edges are delayed a cycle so pointer moves have landed first
   always @(posedge clock) begin
      if (rst) begin
         wrSeen_r <= 1'b0;
         rdSeen_r <= 1'b0;
      end else begin
         wrSeen_r <= syncWr_r ? inRise : inStbRise;
         rdSeen_r <= syncRd_r ? outRise : outStbRise;
      end
   end

   // Threshold flag update by timing style
   always @(posedge clock) begin
      if (rst | ptrClr) begin
         almostEmptyFlagN <= 1'b0;
         almostFullFlagN  <= 1'b1;
      end else if (syncFlags_r) begin
         if (rdSeen_r) begin
            almostEmptyFlagN <= ~aeNow;
         end
         if (wrSeen_r) begin
            almostFullFlagN <= ~afNow;
         end
      end else begin
         // Read edges only pull empty low and release full; writes mirror
         if (rdSeen_r & aeNow) begin
            almostEmptyFlagN <= 1'b0;
         end else if (wrSeen_r & ~aeNow) begin
            almostEmptyFlagN <= 1'b1;
         end
         if (wrSeen_r & afNow) begin
            almostFullFlagN <= 1'b0;
         end else if (rdSeen_r & ~afNow) begin
            almostFullFlagN <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/bmf_fifo_props.sv
// Port checker for the bus-matching buffer
`timescale 1ns/1ps
`default_nettype none
`include "bmf_defs.vh"
module bmf_fifo_props (
   input wire logic                   clock,
   input wire logic                   rst,
   input wire logic                   masterResetN,
   input wire logic                   partialResetN,
   input wire logic                   inClock,
   input wire logic                   inStrobe,
   input wire logic                   outClock,
   input wire logic                   outEnableN,
   input wire logic                   outStrobe,
   input wire logic                   outDriveEnableN,
   input wire logic [`BMF_DATA_W-1:0] outDataBus,
   input wire logic                   outDataOe,
   input wire logic                   echoOutClock,
   input wire logic                   echoOutEnableN,
   input wire logic                   emptyFlagN,
   input wire logic                   fullFlagN,
   input wire logic                   halfLevelFlagN,
   input wire logic                   almostEmptyFlagN,
   input wire logic                   almostFullFlagN
);
   logic       oClkD_r, oStbD_r, iClkD_r, iStbD_r; // Previous port levels
   logic [2:0] rdAge_r, wrAge_r;                   // Cycles since a port edge, saturating
   wire logic  rdEdge = (outClock & ~oClkD_r) | (outStrobe & ~oStbD_r);
   wire logic  wrEdge = (inClock & ~iClkD_r) | (inStrobe & ~iStbD_r);
   ////////////////////////////////////////////////////////////////
   // Edge ages, so flag moves can be tied to the edge that caused them
   always @(posedge clock) begin
      oClkD_r <= outClock;
      oStbD_r <= outStrobe;
      iClkD_r <= inClock;
      iStbD_r <= inStrobe;
      if (rst) begin
         rdAge_r <= 3'h7;
         wrAge_r <= 3'h7;
      end else begin
         rdAge_r <= rdEdge ? 3'h0 : rdAge_r + {2'h0, rdAge_r != 3'h7};
         wrAge_r <= wrEdge ? 3'h0 : wrAge_r + {2'h0, wrAge_r != 3'h7};
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Read port quiet over the last sample
   sequence s_rdQuiet;
      outClock == $past(outClock) && outStrobe == $past(outStrobe);
   endsequence
   sequence s_noReset;
      masterResetN && partialResetN;
   endsequence
   property p_oeOff; outDriveEnableN |-> !outDataOe; endproperty
   property p_echoClk; echoOutClock |-> $past(outClock); endproperty
   property p_echoEn; !echoOutEnableN |-> !$past(outEnableN); endproperty
   property p_rstEmpty;
      $fell(rst) |-> !emptyFlagN && fullFlagN && halfLevelFlagN && !almostEmptyFlagN
         && almostFullFlagN;
   endproperty
   property p_prsEmpty;
      (!partialResetN || !masterResetN) |=> halfLevelFlagN && !almostEmptyFlagN
         && almostFullFlagN;
   endproperty
   property p_busHold; s_rdQuiet ##0 s_noReset |=> $stable(outDataBus); endproperty
   property p_aeFall;
      $fell(almostEmptyFlagN) && $past(masterResetN && partialResetN) |-> rdAge_r <= 3'h3;
   endproperty
   property p_afFall;
      $fell(almostFullFlagN) && $past(masterResetN && partialResetN) |-> wrAge_r <= 3'h3;
   endproperty
   a_oeOff: assert property (p_oeOff) else $error("bus driven while drive off");
   a_echoClk: assert property (p_echoClk) else $error("echo clock wrong");
   a_echoEn: assert property (p_echoEn) else $error("echo enable wrong");
   a_rstEmpty: assert property (p_rstEmpty) else $error("not empty after reset");
   a_prsEmpty: assert property (p_prsEmpty) else $error("flags kept over reset");
   a_busHold: assert property (p_busHold) else $error("read bus moved unread");
   a_aeFall: assert property (p_aeFall) else $error("almost empty fell unread");
   a_afFall: assert property (p_afFall) else $error("almost full fell unwritten");
endmodule
bind bmf_fifo_top bmf_fifo_props u_bmf_fifo_props (.clock(clock), .rst(rst),
   .masterResetN(masterResetN), .partialResetN(partialResetN), .inClock(inClock),
   .inStrobe(inStrobe), .outClock(outClock), .outEnableN(outEnableN),
   .outStrobe(outStrobe), .outDriveEnableN(outDriveEnableN), .outDataBus(outDataBus),
   .outDataOe(outDataOe), .echoOutClock(echoOutClock), .echoOutEnableN(echoOutEnableN),
   .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN), .halfLevelFlagN(halfLevelFlagN),
   .almostEmptyFlagN(almostEmptyFlagN), .almostFullFlagN(almostFullFlagN));
`default_nettype wire

// file: bench/bmf_port_partner.sv
// Producer and consumer port clock model
`timescale 1ns/1ps
`default_nettype none
module bmf_port_partner (
   input  wire logic        clock,
   input  wire logic        wrGo,
   input  wire logic        rdGo,
   input  wire logic [71:0] wrWord,
   output var  logic        inClock,
   output var  logic        outClock,
   output var  logic [71:0] inData
);
   initial begin
      inClock = 1'b0;
      outClock = 1'b0;
      inData = 72'h0;
   end
   // One clock pulse per request, still between; released data inverted
   always @(posedge clock) begin
      inClock <= wrGo;
      outClock <= rdGo;
      inData <= wrGo ? wrWord : ~wrWord;
   end
endmodule
`default_nettype wire

// file: bench/bmf_fifo_top_tb.sv
// Self-checking bench for the bus-matching buffer
`timescale 1ns/1ps
`default_nettype none
module bmf_fifo_top_tb;
   logic clock, rst, masterResetN, partialResetN, inEnableN, outEnableN, wrGo, rdGo;
   logic ftSel, outDriveEnableN, inClock, outClock, emptyFlagN, fullFlagN, halfLevelFlagN;
   logic almostEmptyFlagN, almostFullFlagN, outDataOe;
   logic [71:0] wrWord, inData, outDataBus;
   logic [10:0] cfg; // Mode and control pins
   int miscompares = 0;
   int checks_done = 0;
   bmf_port_partner u_bmf_port_partner (.clock(clock), .wrGo(wrGo), .rdGo(rdGo),
      .wrWord(wrWord), .inClock(inClock), .outClock(outClock), .inData(inData));
   bmf_fifo_top u_bmf_fifo_top (.clock(clock), .rst(rst), .masterResetN(masterResetN),
      .partialResetN(partialResetN), .inClock(inClock), .inEnableN(inEnableN),
      .inStrobe(1'b0), .inTimingStyleSel(cfg[0]), .inPortWidthSel(1'b0),
      .outPortWidthSel(1'b0), .busSizeMatchSel(cfg[1]), .inDataBus(inData),
      .outClock(outClock), .outEnableN(outEnableN), .outStrobe(1'b0),
      .outTimingStyleSel(cfg[2]), .outDriveEnableN(outDriveEnableN),
      .outChipSelectN(cfg[3]),
      .outDataBus(outDataBus), .outDataOe(outDataOe), .echoOutClock(),
      .echoOutEnableN(), .fallthroughSelSerialInput(ftSel), .serialClock(1'b0),
      .serialLoadEnableN(cfg[4]), .offsetLoadSelN(cfg[5]), .defaultOffsetSel0(cfg[6]),
      .defaultOffsetSel1(cfg[7]), .flagTimingSel(cfg[8]), .markIn(cfg[9]),
      .replayRequestN(cfg[10]), .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
      .halfLevelFlagN(halfLevelFlagN), .almostEmptyFlagN(almostEmptyFlagN),
      .almostFullFlagN(almostFullFlagN));
   function automatic logic [71:0] word(input int i);
      word = {9{i[7:0]}};
   endfunction
   task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One port clock pulse, then time for count and threshold flags to settle
   task automatic pulse(input bit wr);
      @(posedge clock);
      if (wr) wrGo <= 1'b1;
      else rdGo <= 1'b1;
      @(posedge clock);
      wrGo <= 1'b0;
      rdGo <= 1'b0;
      repeat (5) @(posedge clock);
   endtask
   // Standard-mode flags for a fill level, preset offset 7 on both thresholds
   task automatic flags(input int c);
      chk("empty", c != 0, emptyFlagN);
      chk("full", c < 64, fullFlagN);
      chk("half", c <= 32, halfLevelFlagN);
      chk("almostEmpty", c > 7, almostEmptyFlagN);
      chk("almostFull", c < 57, almostFullFlagN);
   endtask
   task automatic t_order;
      inEnableN <= 1'b1;
      wrWord <= word(99);
      pulse(1);
      chk("emptyNoEnable", 1'b0, emptyFlagN);
      inEnableN <= 1'b0;
      for (int i = 1; i <= 3; i++) begin
         wrWord <= word(i);
         pulse(1);
      end
      chk("busBeforeRead", 72'h0, outDataBus);
      for (int i = 1; i <= 3; i++) begin
         pulse(0);
         chk("readWord", word(i), outDataBus);
      end
      flags(0);
      outDriveEnableN <= 1'b1;
      #10;
      chk("oeOff", 1'b0, outDataOe);
      outDriveEnableN <= 1'b0;
      #10;
      chk("oeOn", 1'b1, outDataOe);
      $display("t_order done");
   endtask
   task automatic t_fill;
      for (int i = 1; i <= 65; i++) begin
         wrWord <= word(i);
         pulse(1);
         flags(i > 64 ? 64 : i);
      end
      for (int i = 1; i <= 65; i++) begin
         pulse(0);
         chk("drainWord", word(i > 64 ? 64 : i), outDataBus);
         flags(i > 64 ? 0 : 64 - i);
      end
      $display("t_fill done");
   endtask
   task automatic t_partial;
      pulse(1);
      pulse(1);
      partialResetN <= 1'b0;
      @(posedge clock);
      partialResetN <= 1'b1;
      @(posedge clock);
      flags(0);
      wrWord <= word(7);
      pulse(1);
      pulse(0);
      chk("afterPartial", word(7), outDataBus);
      $display("t_partial done");
   endtask
   task automatic t_ft;
      ftSel <= 1'b1;
      cfg[8] <= 1'b1;
      masterResetN <= 1'b0;
      repeat (2) @(posedge clock);
      masterResetN <= 1'b1;
      outEnableN <= 1'b1;
      @(posedge clock);
      chk("ftEmpty", 1'b1, emptyFlagN);
      chk("ftSpace", 1'b0, fullFlagN);
      wrWord <= word(5);
      pulse(1);
      chk("ftNoEdges", 72'h0, outDataBus);
      wrWord <= word(6);
      pulse(1);
      pulse(0);
      pulse(0);
      chk("ftFirst", word(5), outDataBus);
      chk("ftValid", 1'b0, emptyFlagN);
      pulse(0);
      chk("ftNeedsEnable", word(5), outDataBus);
      $display("t_ft done");
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      complete_run;
   end
   initial begin
      {rst, masterResetN, partialResetN, outDriveEnableN, cfg} = 15'h7c35;
      {inEnableN, outEnableN, wrGo, rdGo, ftSel} = 5'h0;
      wrWord = 72'h0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      flags(0);
      t_order;
      t_fill;
      t_partial;
      t_ft;
      complete_run;
   end
endmodule
`default_nettype wire
